// >>> verilog/pps_pkg.sv
// Package for the port pin mode and select block
// Notes on behaviour
// - Each pin has a two-bit mode; port2 pins 0,1 use misc control bits 1:0, 3:2.
// - Port0 modes: pins 0-3 in low register, 4-7 in high, higher pin higher bits.
// - Port1 modes: pins 0-3 in low register, 4-7 in high, two bits each.
// - Port3 modes: pins 0-3 in low register, 4-7 in high, two bits each.
// - Only port2 data bits 1 and 0 exist; they drive and report pins 1 and 0.
// - Serial select 0: transmit on port3 pin1, receive port3 pin0; 1: port1 pin6, port0 pin2.
// - With serial select 1 the transmit and receive pins act open-drain.
// - Timer2 wave enable puts overflow divided by 2 on port1 pin 0.
// - Timer1 wave enable puts overflow divided by 2 on port3 pin 5.
// - Timer0 wave enable puts overflow divided by 64 on port3 pin 4.
// - LCD bias bits 0-3 turn port1 pins 2-5 into half-bias outputs.
// - Bandgap enable routes the reference to port3 pin 2.
// - Modes 0 and 1 pull low on data 0, float on 1; mode 0 adds pull-up.
// - Mode 2 drives push-pull following the data bit.
// - Mode 3 is high impedance with the digital input buffer off.
// - Read-modify-write reads of a port return the latch, not the pins.
package pps_pkg;
    // Register addresses in the special function space
    localparam logic [7:0] ADDR_PORT0 = 8'h80;
    localparam logic [7:0] ADDR_PORT1 = 8'h90;
    localparam logic [7:0] ADDR_P0_MODE_LOW = 8'h91;
    localparam logic [7:0] ADDR_P0_MODE_HIGH = 8'h92;
    localparam logic [7:0] ADDR_MISC_PIN = 8'h93;
    localparam logic [7:0] ADDR_PORT2 = 8'ha0;
    localparam logic [7:0] ADDR_P1_MODE_LOW = 8'ha2;
    localparam logic [7:0] ADDR_P1_MODE_HIGH = 8'ha3;
    localparam logic [7:0] ADDR_P3_MODE_LOW = 8'ha4;
    localparam logic [7:0] ADDR_P3_MODE_HIGH = 8'ha5;
    localparam logic [7:0] ADDR_LCD_BIAS = 8'haf;
    localparam logic [7:0] ADDR_PORT3 = 8'hb0;
    localparam logic [7:0] ADDR_AUX_TWO = 8'hf7;
    // Field positions
    localparam int SERIAL_SEL_BIT = 7;
    localparam int T2_OE_BIT = 6;
    localparam int T1_OE_BIT = 5;
    localparam int T0_OE_BIT = 4;
    localparam int P2_PIN1_MODE_LSB = 2;
    localparam int P2_PIN0_MODE_LSB = 0;
    localparam int BANDGAP_BIT = 4;
    localparam int LCD_BIAS_W = 4;
    localparam int P2_DATA_W = 2;
    // Reset values
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] MODE_RST = 8'h55;
    localparam logic [7:0] MISC_PIN_RST = 8'h05;
    localparam logic [7:0] AUX_TWO_RST = 8'h06;
    // Timer0 wave divides overflow by 64: a six-bit count
    localparam int T0_DIV_W = 6;
    // Pin layout: port n pin b sits at index 8*n+b
    localparam int NPINS = 32;
    localparam int PIN_P0_2 = 2;
    localparam int PIN_P1_0 = 8;
    localparam int PIN_P1_2 = 10;
    localparam int PIN_P1_6 = 14;
    localparam int PIN_P3_0 = 24;
    localparam int PIN_P3_1 = 25;
    localparam int PIN_P3_2 = 26;
    localparam int PIN_P3_4 = 28;
    localparam int PIN_P3_5 = 29;

    typedef enum logic [1:0] {
        OPEN_DRAIN_PULLUP_MODE,
        OPEN_DRAIN_MODE,
        PUSH_PULL_MODE,
        ANALOG_MODE
    } pps_mode_e;

    // Drive controls of one pad
    typedef struct packed {
        logic oe;
        logic out;
        logic pu;
        logic ie;
        logic ana;
    } pps_pin_s;

    // Register bus request from the core
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic rmw;
        logic [7:0] wdata;
    } pps_sfr_s;
endpackage

// >>> verilog/pps_port_ctrl.sv
// Port data latches, pin modes and alternate function routing
`timescale 1ns/1ps
`default_nettype none
module pps_port_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire pps_pkg::pps_sfr_s sfr,
    output logic [7:0] sfr_rdata_ff,
    input wire logic [pps_pkg::NPINS-1:0] pad_in,
    output pps_pkg::pps_pin_s [pps_pkg::NPINS-1:0] pad_ctl_ff,
    input wire logic uart_tx,
    output logic uart_rx_ff,
    input wire logic t0_ovf,
    input wire logic t1_ovf,
    input wire logic t2_ovf,
    output logic [pps_pkg::LCD_BIAS_W-1:0] lcd_bias_ff,
    output logic bandgap_ff
);
    import pps_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] data_ff [4];
    logic [7:0] mode_ff [6];
    logic [7:0] misc_ff;
    logic [7:0] aux_ff;
    logic [7:0] nxt_data [4];
    logic [7:0] nxt_mode [6];
    logic [7:0] nxt_misc;
    logic [7:0] nxt_aux;
    logic [LCD_BIAS_W-1:0] nxt_lcd;
    logic [7:0] nxt_rdata;
    logic [NPINS-1:0] sync1_ff;
    logic [NPINS-1:0] sync2_ff;
    logic [T0_DIV_W-1:0] t0_cnt_ff;
    logic [T0_DIV_W-1:0] nxt_t0_cnt;
    logic t1_wave_ff;
    logic t2_wave_ff;
    logic nxt_t1_wave;
    logic nxt_t2_wave;
    pps_pin_s [NPINS-1:0] nxt_pad;
    logic nxt_rx;
    logic [NPINS-1:0] pin_lvl;
    logic [31:0] lat_flat;

    // Mode field of a pin from the mode registers
    function automatic pps_mode_e mode_of(input int idx);
        int b;
        logic [1:0] m;
        b = idx % 8;
        m = 2'h1;
        unique case (idx / 8)
            0: m = mode_ff[b / 4][2 * (b % 4) +: 2];
            1: m = mode_ff[2 + b / 4][2 * (b % 4) +: 2];
            2: begin
                if (b == 0) begin
                    m = misc_ff[P2_PIN0_MODE_LSB +: 2];
                end else if (b == 1) begin
                    m = misc_ff[P2_PIN1_MODE_LSB +: 2];
                end else begin
                    m = 2'h3;
                end
            end
            3: m = mode_ff[4 + b / 4][2 * (b % 4) +: 2];
            default: m = 2'h1;
        endcase
        return pps_mode_e'(m);
    endfunction

    assign lat_flat = {data_ff[3], data_ff[2], data_ff[1], data_ff[0]};
    // Pin levels, zero where the input buffer is off
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pin_lvl[i] = sync2_ff[i] & pad_ctl_ff[i].ie;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register writes and reads
    always_comb begin
        nxt_data = data_ff;
        nxt_mode = mode_ff;
        nxt_misc = misc_ff;
        nxt_aux = aux_ff;
        nxt_lcd = lcd_bias_ff;
        nxt_rdata = sfr_rdata_ff;
        if (sfr.wr) begin
            unique case (sfr.addr)
                ADDR_PORT0: nxt_data[0] = sfr.wdata;
                ADDR_PORT1: nxt_data[1] = sfr.wdata;
                ADDR_PORT2: nxt_data[2] = {6'h3f, sfr.wdata[P2_DATA_W-1:0]};
                ADDR_PORT3: nxt_data[3] = sfr.wdata;
                ADDR_P0_MODE_LOW: nxt_mode[0] = sfr.wdata;
                ADDR_P0_MODE_HIGH: nxt_mode[1] = sfr.wdata;
                ADDR_P1_MODE_LOW: nxt_mode[2] = sfr.wdata;
                ADDR_P1_MODE_HIGH: nxt_mode[3] = sfr.wdata;
                ADDR_P3_MODE_LOW: nxt_mode[4] = sfr.wdata;
                ADDR_P3_MODE_HIGH: nxt_mode[5] = sfr.wdata;
                ADDR_MISC_PIN: nxt_misc = sfr.wdata;
                ADDR_LCD_BIAS: nxt_lcd = sfr.wdata[LCD_BIAS_W-1:0];
                ADDR_AUX_TWO: nxt_aux = sfr.wdata;
                default: nxt_rdata = sfr_rdata_ff;
            endcase
        end
        if (sfr.rd) begin
            unique case (sfr.addr)
                ADDR_PORT0: nxt_rdata = sfr.rmw ? data_ff[0] : pin_lvl[7:0];
                ADDR_PORT1: nxt_rdata = sfr.rmw ? data_ff[1] : pin_lvl[15:8];
                ADDR_PORT2: nxt_rdata = {6'h00, sfr.rmw ? data_ff[2][1:0] : pin_lvl[17:16]};
                ADDR_PORT3: nxt_rdata = sfr.rmw ? data_ff[3] : pin_lvl[31:24];
                ADDR_P0_MODE_LOW: nxt_rdata = mode_ff[0];
                ADDR_P0_MODE_HIGH: nxt_rdata = mode_ff[1];
                ADDR_P1_MODE_LOW: nxt_rdata = mode_ff[2];
                ADDR_P1_MODE_HIGH: nxt_rdata = mode_ff[3];
                ADDR_P3_MODE_LOW: nxt_rdata = mode_ff[4];
                ADDR_P3_MODE_HIGH: nxt_rdata = mode_ff[5];
                ADDR_MISC_PIN: nxt_rdata = misc_ff;
                ADDR_LCD_BIAS: nxt_rdata = {4'h0, lcd_bias_ff};
                ADDR_AUX_TWO: nxt_rdata = aux_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // Register bank; reset wins over the clock enable
    always_ff @(posedge clk) begin
        if (rst) begin
            // ones in latches, 01 in modes
            for (int i = 0; i < 4; i++) begin
                data_ff[i] <= DATA_RST;
            end
            for (int i = 0; i < 6; i++) begin
                mode_ff[i] <= MODE_RST;
            end
            // Serial select and wave enables start clear, port2 fields at 01
            misc_ff <= MISC_PIN_RST;
            aux_ff <= AUX_TWO_RST;
            lcd_bias_ff <= '0;
            sfr_rdata_ff <= 8'h00;
        end else if (ce) begin
            data_ff <= nxt_data;
            mode_ff <= nxt_mode;
            misc_ff <= nxt_misc;
            aux_ff <= nxt_aux;
            lcd_bias_ff <= nxt_lcd;
            sfr_rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Timer waveform dividers
    always_comb begin
        nxt_t0_cnt = t0_ovf ? t0_cnt_ff + 6'h01 : t0_cnt_ff;
        nxt_t1_wave = t1_wave_ff ^ t1_ovf;
        nxt_t2_wave = t2_wave_ff ^ t2_ovf;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            t0_cnt_ff <= '0;
            t1_wave_ff <= 1'b0;
            t2_wave_ff <= 1'b0;
        end else if (ce) begin
            t0_cnt_ff <= nxt_t0_cnt;
            t1_wave_ff <= nxt_t1_wave;
            t2_wave_ff <= nxt_t2_wave;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pad drive; timer waves override the latch value, transmit is ANDed with it, LCD bias and bandgap force analog
    always_comb begin
        logic d;
        logic od;
        logic an;
        pps_mode_e m;
        d = 1'b0;
        od = 1'b0;
        an = 1'b0;
        m = OPEN_DRAIN_MODE;
        for (int i = 0; i < NPINS; i++) begin
            m = mode_of(i);
            d = lat_flat[i];
            od = 1'b0;
            an = 1'b0;
            if (!misc_ff[SERIAL_SEL_BIT] && i == PIN_P3_1) begin
                d = d & uart_tx;
            end
            if (misc_ff[SERIAL_SEL_BIT] && i == PIN_P1_6) begin
                d = d & uart_tx;
            end
            if (misc_ff[SERIAL_SEL_BIT] && (i == PIN_P1_6 || i == PIN_P0_2)) begin
                od = 1'b1;
            end
            if (misc_ff[T2_OE_BIT] && i == PIN_P1_0) begin
                d = t2_wave_ff;
            end
            if (misc_ff[T1_OE_BIT] && i == PIN_P3_5) begin
                d = t1_wave_ff;
            end
            if (misc_ff[T0_OE_BIT] && i == PIN_P3_4) begin
                d = t0_cnt_ff[T0_DIV_W-1];
            end
            if (i >= PIN_P1_2 && i < PIN_P1_2 + LCD_BIAS_W) begin
                an = lcd_bias_ff[i - PIN_P1_2];
            end
            if (aux_ff[BANDGAP_BIT] && i == PIN_P3_2) begin
                an = 1'b1;
            end
            nxt_pad[i] = '0;
            if (an) begin
                nxt_pad[i].ana = 1'b1;
            end else if (m == PUSH_PULL_MODE && !od) begin
                nxt_pad[i].oe = 1'b1;
                nxt_pad[i].out = d;
                nxt_pad[i].ie = 1'b1;
            end else if (m == ANALOG_MODE) begin
                nxt_pad[i].ana = 1'b1;
            end else begin
                // open drain, pull-up in mode 0
                nxt_pad[i].oe = !d;
                nxt_pad[i].ie = 1'b1;
                nxt_pad[i].pu = d && (m == OPEN_DRAIN_PULLUP_MODE);
            end
        end
        // receive source; pin reads as given by its buffer
        nxt_rx = misc_ff[SERIAL_SEL_BIT] ? pin_lvl[PIN_P0_2] : pin_lvl[PIN_P3_0];
    end

    // Pad flops and two-stage input synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            pad_ctl_ff <= '0;
            uart_rx_ff <= 1'b1;
            bandgap_ff <= 1'b0;
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (ce) begin
            pad_ctl_ff <= nxt_pad;
            uart_rx_ff <= nxt_rx;
            bandgap_ff <= aux_ff[BANDGAP_BIT];
            sync1_ff <= pad_in;
            sync2_ff <= sync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // First edge after release still shows the reset contents
    AST_RESET_STATE: assert property (
        $fell(rst) |-> data_ff[0] == DATA_RST && mode_ff[5] == MODE_RST
        && misc_ff == MISC_PIN_RST)
        else $error("reset state wrong");
    AST_P0_FIELD: assert property (
        ce && sfr.wr && sfr.addr == ADDR_P0_MODE_HIGH && sfr.wdata[3:2] == 2'h2
        |=> mode_of(5) == PUSH_PULL_MODE)
        else $error("port0 pin5 mode field wrong");
    AST_PUSH_PULL: assert property (
        ce && mode_of(1) == PUSH_PULL_MODE
        |=> pad_ctl_ff[1].oe && pad_ctl_ff[1].out == $past(data_ff[0][1]))
        else $error("push-pull drive wrong");
    AST_OPEN_DRAIN: assert property (
        ce && mode_of(1) == OPEN_DRAIN_PULLUP_MODE
        |=> pad_ctl_ff[1].oe == !$past(data_ff[0][1]) && pad_ctl_ff[1].pu == $past(data_ff[0][1]))
        else $error("open-drain drive wrong");
    AST_ANALOG: assert property (
        ce && mode_of(1) == ANALOG_MODE |=> !pad_ctl_ff[1].oe && !pad_ctl_ff[1].ie)
        else $error("analog pin not released");
    AST_SERIAL_OD: assert property (
        ce && misc_ff[SERIAL_SEL_BIT] |=> pad_ctl_ff[PIN_P1_6].out == 1'b0)
        else $error("serial pin not open drain");
    AST_TX_ROUTE: assert property (
        ce && !misc_ff[SERIAL_SEL_BIT] && mode_of(PIN_P3_1) == OPEN_DRAIN_MODE && data_ff[3][1]
        |=> pad_ctl_ff[PIN_P3_1].oe == !$past(uart_tx))
        else $error("transmit not on port3 pin1");
    AST_T2_WAVE: assert property (
        ce && misc_ff[T2_OE_BIT] && mode_of(PIN_P1_0) == PUSH_PULL_MODE
        |=> pad_ctl_ff[PIN_P1_0].out == $past(t2_wave_ff))
        else $error("timer2 wave missing");
    AST_LCD_BIAS: assert property (
        ce && lcd_bias_ff[0] |=> pad_ctl_ff[PIN_P1_2].ana && !pad_ctl_ff[PIN_P1_2].oe)
        else $error("lcd bias pin not analog");
    AST_BANDGAP: assert property (
        ce && aux_ff[BANDGAP_BIT] |=> pad_ctl_ff[PIN_P3_2].ana && bandgap_ff)
        else $error("bandgap not routed");
    AST_RMW_READ: assert property (
        ce && sfr.rd && sfr.rmw && sfr.addr == ADDR_PORT1 |=> sfr_rdata_ff == $past(data_ff[1]))
        else $error("rmw read not from latch");
    AST_P2_READ: assert property (
        ce && sfr.rd && sfr.addr == ADDR_PORT2 |=> sfr_rdata_ff[7:2] == 6'h00)
        else $error("port2 upper bits not zero");
    AST_T0_DIV: assert property (
        ce && t0_ovf && t0_cnt_ff == 6'h1f |=> t0_cnt_ff == 6'h20)
        else $error("timer0 divider wrong");
    AST_P2_MODE: assert property (
        ce && sfr.wr && sfr.addr == ADDR_MISC_PIN && sfr.wdata[3:2] == 2'h3
        |=> mode_of(17) == ANALOG_MODE)
        else $error("port2 pin1 mode wrong");

    COV_SERIAL_ALT: cover property (ce && misc_ff[SERIAL_SEL_BIT] && !uart_tx);
    COV_T0_WRAP: cover property (ce && t0_ovf && t0_cnt_ff == 6'h3f);
    COV_PIN_READ: cover property (ce && sfr.rd && !sfr.rmw && sfr.addr == ADDR_PORT0);
endmodule
`default_nettype wire

// >>> bench/pps_pad_model.sv
// External circuitry model on the port pins: drivers, pull-ups and floating lines
`timescale 1ns/1ps
`default_nettype none
module pps_pad_model (
    input wire logic clk,
    input wire pps_pkg::pps_pin_s [pps_pkg::NPINS-1:0] pad_ctl,
    input wire logic [pps_pkg::NPINS-1:0] ext_en,
    input wire logic [pps_pkg::NPINS-1:0] ext_val,
    output logic [pps_pkg::NPINS-1:0] pad_lvl
);
    import pps_pkg::*;
    logic flip;
    ////////////////////////////////////////////////////////////////////////////////
    // A floating line changes every cycle, so a stale value never passes for a level;
    // it moves on the falling edge to stay clear of the synchroniser's sampling edge
    initial begin
        flip = 1'b0;
        forever @(negedge clk) flip = ~flip;
    end
    // Chip drive wins, then the outside driver, then the internal pull-up
    // drive and pull-up
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pad_ctl[i].oe)
                pad_lvl[i] = pad_ctl[i].out;
            else if (ext_en[i])
                pad_lvl[i] = ext_val[i];
            else if (pad_ctl[i].pu)
                pad_lvl[i] = 1'b1;
            else
                pad_lvl[i] = flip;
        end
    end
endmodule
`default_nettype wire

// >>> bench/port_pin_mode_and_select_tb.sv
// Self-checking bench for the port pin mode and select block
`timescale 1ns/1ps
`default_nettype none
module port_pin_mode_and_select_tb;
    import pps_pkg::*;
    logic clk;
    logic rst;
    logic ce;
    pps_sfr_s sfr;
    logic [7:0] rdata;
    logic [NPINS-1:0] pad_in;
    pps_pin_s [NPINS-1:0] pad;
    logic uart_tx;
    logic uart_rx;
    logic [2:0] ovf;
    logic [LCD_BIAS_W-1:0] lcd;
    logic bandgap;
    logic [NPINS-1:0] ext_en;
    logic [NPINS-1:0] ext_val;
    logic [4:0] e;
    logic [4:0] k;
    logic b;
    int miscompares;
    int n_checks;
    logic [7:0] ra[14] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'h91, 8'h92, 8'ha2, 8'ha3, 8'ha4,
                            8'ha5, 8'h93, 8'haf, 8'hf7, 8'h81};
    logic [7:0] rv[14] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55,
                            8'h55, 8'h05, 8'h00, 8'h06, 8'h00};
    logic [7:0] rm[14] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                            8'hff, 8'hff, 8'h0f, 8'hff, 8'h00};
    logic [7:0] ma[8] = '{8'h91, 8'h92, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'h93, 8'h93};
    logic [7:0] mb[8] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h05, 8'h05};
    int ml[8] = '{2, 2, 2, 6, 6, 4, 0, 2};
    logic [7:0] da[8] = '{8'h80, 8'h80, 8'h90, 8'h90, 8'hb0, 8'hb0, 8'ha0, 8'ha0};
    int db[8] = '{1, 5, 1, 7, 3, 6, 0, 1};

    pps_port_ctrl pps_port_ctrl_inst (.clk(clk), .rst(rst), .ce(ce), .sfr(sfr),
        .sfr_rdata_ff(rdata), .pad_in(pad_in), .pad_ctl_ff(pad), .uart_tx(uart_tx),
        .uart_rx_ff(uart_rx), .t0_ovf(ovf[0]), .t1_ovf(ovf[1]), .t2_ovf(ovf[2]),
        .lcd_bias_ff(lcd), .bandgap_ff(bandgap));
    pps_pad_model pps_pad_model_inst (.clk(clk), .pad_ctl(pad), .ext_en(ext_en),
        .ext_val(ext_val), .pad_lvl(pad_in));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pad fields compared as {oe, driven level, pull-up, input buffer, analog}
    task automatic chk_pad(input string what, input int i, input logic [4:0] ex,
                           input logic [4:0] msk);
        logic [4:0] g;
        g = {pad[i].oe, pad[i].oe & pad[i].out, pad[i].pu, pad[i].ie, pad[i].ana};
        chk(what, {3'h0, ex & msk}, {3'h0, g & msk});
    endtask

    // Requests launch just after an edge and drop after the sampling edge
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        sfr.addr = a;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        @(posedge clk);
        #2;
        sfr.wr = 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic rw,
                          input logic [7:0] exp);
        @(posedge clk);
        #2;
        sfr.addr = a;
        sfr.rmw = rw;
        sfr.rd = 1'b1;
        @(posedge clk);
        #2;
        sfr.rd = 1'b0;
        @(posedge clk);
        #2;
        chk(what, exp, rdata);
    endtask

    // Pads follow a write two edges later; pin reads need the synchroniser too
    task automatic settle();
        repeat (4) @(posedge clk);
        #2;
    endtask

    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
            ovf = 3'b001 << which;
            @(posedge clk);
            #2;
            ovf = 3'b000;
        end
        settle();
    endtask

    // Watchdog: the sequence needs well under 10k cycles
    initial begin
        #1_000_000;
        miscompares++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        sfr = '0;
        uart_tx = 1'b1;
        ovf = 3'b000;
        ext_en = '0;
        ext_val = '0;
        miscompares = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        settle();
        // Reset values, write and read back, unmapped place, then restore
        for (int i = 0; i < 14; i++) begin
            rd_chk("reset value", ra[i], 1'b1, rv[i]);
            reg_wr(ra[i], 8'h3c);
            rd_chk("readback", ra[i], 1'b1, 8'h3c & rm[i]);
            reg_wr(ra[i], rv[i]);
        end
        // Frozen clock enable ignores a write
        ce = 1'b0;
        reg_wr(8'h91, 8'h00);
        ce = 1'b1;
        rd_chk("ce hold", 8'h91, 1'b1, 8'h55);
        // Timer0 wave toggles on the 32nd overflow (divide by 64)
        reg_wr(8'h93, 8'h75);
        reg_wr(8'ha5, 8'h5a);
        reg_wr(8'ha2, 8'h56);
        settle();
        chk_pad("t0 wave start", PIN_P3_4, 5'b10000, 5'b11000);
        pulse(0, 31);
        chk_pad("t0 wave 31", PIN_P3_4, 5'b10000, 5'b11000);
        pulse(0, 1);
        chk_pad("t0 wave 32", PIN_P3_4, 5'b11000, 5'b11000);
        // Timer1 and timer2 waves toggle on each overflow
        b = pad[PIN_P3_5].out;
        pulse(1, 1);
        chk_pad("t1 wave", PIN_P3_5, {1'b1, ~b, 3'h0}, 5'b11000);
        b = pad[PIN_P1_0].out;
        pulse(2, 1);
        chk_pad("t2 wave", PIN_P1_0, {1'b1, ~b, 3'h0}, 5'b11000);
        reg_wr(8'h93, 8'h05);
        reg_wr(8'hb0, 8'hcf);
        // Latch opposite to the last wave level, so a stuck enable shows
        reg_wr(8'h90, 8'hfe);
        settle();
        chk_pad("t2 off", PIN_P1_0, 5'b10000, 5'b11000);
        chk_pad("t1 off", PIN_P3_5, 5'b10000, 5'b11000);
        chk_pad("t0 off", PIN_P3_4, 5'b10000, 5'b11000);
        reg_wr(8'hb0, 8'hff);
        reg_wr(8'ha5, 8'h55);
        reg_wr(8'ha2, 8'h55);
        // Every mode with both data values on one pin of each port mode register and on both port2 pins
        for (int p = 0; p < 8; p++) begin
            for (int m = 0; m < 4; m++) begin
                for (int d = 0; d < 2; d++) begin
                    reg_wr(ma[p], (mb[p] & ~(8'h03 << ml[p])) | (8'(m) << ml[p]));
                    reg_wr(da[p], (d == 1) ? 8'hff : ~(8'h01 << db[p]));
                    settle();
                    case (m)
                        2: begin
                            e = {1'b1, 1'(d), 3'h0};
                            k = 5'b11100;
                        end
                        3: begin
                            e = 5'b00000;
                            k = 5'b10110;
                        end
                        default: begin
                            e = (d == 1) ? {2'b00, 1'(m == 0), 2'b10} : 5'b10000;
                            k = (d == 1) ? 5'b11110 : 5'b11000;
                        end
                    endcase
                    chk_pad("pin mode", 8 * int'((da[p] - 8'h80) >> 4) + db[p], e, k);
                end
            end
            reg_wr(ma[p], mb[p]);
        end
        // Plain reads see pins, read-modify-write reads see the latch
        ext_en[7:0] = 8'hff;
        ext_val[7:0] = 8'hdf;
        settle();
        rd_chk("pin read", 8'h80, 1'b0, 8'hdf);
        rd_chk("latch read", 8'h80, 1'b1, 8'hff);
        reg_wr(8'h92, 8'h5d);
        ext_val[7:0] = 8'hff;
        settle();
        rd_chk("analog read", 8'h80, 1'b0, 8'hdf);
        reg_wr(8'h92, 8'h55);
        // Serial routing on both pin pairs
        uart_tx = 1'b0;
        ext_en[PIN_P3_0] = 1'b1;
        settle();
        chk_pad("tx sel0", PIN_P3_1, 5'b10000, 5'b11000);
        chk_pad("tx sel0 idle", PIN_P1_6, 5'b00000, 5'b10000);
        chk("rx sel0", 8'h00, {7'h0, uart_rx});
        reg_wr(8'h93, 8'h85);
        ext_val[PIN_P0_2] = 1'b1;
        settle();
        chk_pad("tx sel1", PIN_P1_6, 5'b10000, 5'b11000);
        chk_pad("tx sel1 idle", PIN_P3_1, 5'b00000, 5'b10000);
        chk("rx sel1", 8'h01, {7'h0, uart_rx});
        ext_val[PIN_P0_2] = 1'b0;
        settle();
        chk("rx sel1 low", 8'h00, {7'h0, uart_rx});
        // Open-drain even with push-pull mode selected
        reg_wr(8'ha3, 8'h65);
        uart_tx = 1'b1;
        settle();
        chk_pad("tx open drain", PIN_P1_6, 5'b00000, 5'b10000);
        reg_wr(8'h93, 8'h05);
        reg_wr(8'ha3, 8'h55);
        // LCD bias pins one at a time
        for (int i = 0; i < LCD_BIAS_W; i++) begin
            reg_wr(8'haf, 8'h01 << i);
            settle();
            chk("lcd enables", 8'h01 << i, {4'h0, lcd});
            chk_pad("lcd pin", PIN_P1_2 + i, 5'b00001, 5'b10001);
        end
        reg_wr(8'haf, 8'h00);
        // Bandgap output on and off
        reg_wr(8'hf7, 8'h16);
        settle();
        chk("bandgap on", 8'h01, {7'h0, bandgap});
        chk_pad("bandgap pin", PIN_P3_2, 5'b00001, 5'b10001);
        reg_wr(8'hf7, 8'h06);
        settle();
        chk("bandgap off", 8'h00, {7'h0, bandgap});
        chk_pad("bandgap pin off", PIN_P3_2, 5'b00000, 5'b00001);
        end_of_test();
    end
endmodule
`default_nettype wire
